// File: rtl/cafe_regs.vh
/*
 acceptance filter and error counter block: register offsets, field positions and reset values.
 assumes an 8-bit register port with word-indexed offsets chosen for this block.
*/
`ifndef CAFE_REGS_VH
`define CAFE_REGS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CAFE_OFS_CODE0    5'h00
`define CAFE_OFS_MASK0    5'h08
`define CAFE_OFS_CTRL     5'h10
`define CAFE_OFS_MISC     5'h11
`define CAFE_OFS_RXERR    5'h12
`define CAFE_OFS_TXERR    5'h13
`define CAFE_OFS_IRQ_STAT 5'h14
`define CAFE_OFS_IRQ_MASK 5'h15

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CAFE_CTRL_ORG_LO  4
`define CAFE_CTRL_ORG_HI  5
`define CAFE_CTRL_HIT_HI  2
`define CAFE_CTRL_RECOVERY_ON_REQUEST_SELECT    7
`define CAFE_MISC_HOLD    0
`define CAFE_IRQ_ACCEPT   0
`define CAFE_IRQ_REJECT   1
`define CAFE_IRQ_BUSOFF   2

// ------------------------------------------------------------
// organization codes and reset values
// ------------------------------------------------------------
`define CAFE_ORG_32       2'h0
`define CAFE_ORG_16       2'h1
`define CAFE_ORG_8        2'h2
`define CAFE_ORG_CLOSED   2'h3
`define CAFE_RST_BYTE     8'h00
`define CAFE_RST_ORG      2'h0

`endif

// File: rtl/cafe_top.v
/*
 acceptance filter, error counter views and bus-off hold flag of a can controller.
 assumes the protocol engine supplies frame identifier bytes with a one-cycle
 frame strobe, error counts, bus-off entry pulse and the mode handshakes.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cafe_regs.vh"

// Operation
// - misc register always readable; writing one clears hold flag, zero ignored
// - with recovery on request, bus-off entry sets hold flag; stays until cleared
// - software clears hold flag to request recovery; flag then reads zero
// - receive error count shown read-only; writes do nothing
// - transmit error count shown read-only; writes do nothing
// - every frame lands in background buffer; accepted and rejected ones each set their own status bit
// - code bits compared bit by bit against four identifier bytes
// - in 2x32 organization, extended frames use all four pairs; standard frames only first two
// - eight 8-bit code registers in two banks of four
// - clear mask bit requires equality, set bit is don't-care; all must match
// - code and mask readable always; writable only in acknowledged init mode
// - organization selects 2x32, 4x16, 8x8 filters or closed
// - hit index names accepting filter; updated on move into foreground buffer
module cafe_top #(
   parameter NUM_FILT_REGS = 8
) (
   // clock and reset
   input  wire        CLOCK_IN,
   input  wire        ARST_N_IN,
   // register port
   input  wire [4:0]  ADDR_IN,
   input  wire [7:0]  WDATA_IN,
   input  wire        WR_IN,
   input  wire        RD_IN,
   output reg  [7:0]  RDATA_OUT,
   // mode handshakes
   input  wire        INIT_REQUEST_IN,
   input  wire        INIT_ACKNOWLEDGE_IN,
   input  wire        SLEEP_REQUEST_IN,
   input  wire        SLEEP_ACKNOWLEDGE_IN,
   // protocol engine side
   input  wire [7:0]  RX_ERR_COUNT_IN,
   input  wire [7:0]  TX_ERR_COUNT_IN,
   input  wire        BUSOFF_ENTER_IN,
   input  wire        FRAME_VALID_IN,
   input  wire        FRAME_EXTENDED_IN,
   input  wire [31:0] FRAME_ID_IN,
   input  wire        FG_LOAD_IN,
   output reg         FRAME_ACCEPT_OUT,
   output reg         FRAME_DROP_OUT,
   output reg         BUSOFF_HOLD_OUT,
   output reg         IRQ_OUT
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg  [7:0] code_r [0:NUM_FILT_REGS-1];
   reg  [7:0] mask_r [0:NUM_FILT_REGS-1];
   reg  [1:0] org_r;
   reg        recovery_on_request_select_r;
   reg        hold_r;
   reg  [2:0] bg_hit_r;
   reg        bg_acc_r;
   reg  [2:0] hit_r;
   reg  [2:0] irq_stat_r;
   reg  [2:0] irq_mask_r;
   reg  [7:0] rx_err_r;
   reg  [7:0] tx_err_r;
   reg  [7:0] rdata_nxt;
   reg        accept_nxt;
   reg  [2:0] hit_nxt;
   integer    i;
   // separate loop index so the decode and the register process never share a variable
   integer    j;

   wire       init_mode = INIT_REQUEST_IN & INIT_ACKNOWLEDGE_IN;
   wire       wr_misc   = WR_IN & (ADDR_IN == `CAFE_OFS_MISC);
   wire       rd_stat   = RD_IN & (ADDR_IN == `CAFE_OFS_IRQ_STAT);

   // ------------------------------------------------------------
   // match helper
   // ------------------------------------------------------------
   // one byte matches when every unmasked bit agrees
   function byte_hit;
      input [7:0] id;
      input [7:0] code;
      input [7:0] mask;
      begin
         byte_hit = &(~(id ^ code) | mask);
      end
   endfunction

   // ------------------------------------------------------------
   // filter decode
   // ------------------------------------------------------------
   reg [7:0] idb [0:3];
   reg       m   [0:7];
   always @* begin
      idb[0] = FRAME_ID_IN[31:24];
      idb[1] = FRAME_ID_IN[23:16];
      idb[2] = FRAME_ID_IN[15:8];
      idb[3] = FRAME_ID_IN[7:0];
      for (j = 0; j < 8; j = j + 1) begin
         m[j] = byte_hit(idb[j % 4], code_r[j], mask_r[j]);
      end
      accept_nxt = 1'b0;
      hit_nxt    = 3'h0;
      case (org_r)
         `CAFE_ORG_32: begin
            // standard ids never check the trailing pairs
            if (m[0] & m[1] & (~FRAME_EXTENDED_IN | (m[2] & m[3]))) begin
               accept_nxt = 1'b1;
               hit_nxt    = 3'h0;
            end else if (m[4] & m[5] & (~FRAME_EXTENDED_IN | (m[6] & m[7]))) begin
               accept_nxt = 1'b1;
               hit_nxt    = 3'h1;
            end
         end
         `CAFE_ORG_16: begin
            // 16-bit filters each face the first two identifier bytes
            if (byte_hit(idb[0], code_r[0], mask_r[0]) & m[1]) begin
               accept_nxt = 1'b1;
               hit_nxt    = 3'h0;
            end else if (byte_hit(idb[0], code_r[2], mask_r[2])
                         & byte_hit(idb[1], code_r[3], mask_r[3])) begin
               accept_nxt = 1'b1;
               hit_nxt    = 3'h1;
            end else if (m[4] & m[5]) begin
               accept_nxt = 1'b1;
               hit_nxt    = 3'h2;
            end else if (byte_hit(idb[0], code_r[6], mask_r[6])
                         & byte_hit(idb[1], code_r[7], mask_r[7])) begin
               accept_nxt = 1'b1;
               hit_nxt    = 3'h3;
            end
         end
         `CAFE_ORG_8: begin
            // 8-bit filters all look at the leading identifier byte
            for (j = 7; j >= 0; j = j - 1) begin
               if (byte_hit(idb[0], code_r[j], mask_r[j])) begin
                  accept_nxt = 1'b1;
                  hit_nxt    = j[2:0];
               end
            end
         end
         `CAFE_ORG_CLOSED: begin
            accept_nxt = 1'b0;
         end
         default: begin
            accept_nxt = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always @* begin
      rdata_nxt = `CAFE_RST_BYTE;
      if (ADDR_IN < `CAFE_OFS_MASK0) begin
         rdata_nxt = code_r[ADDR_IN[2:0]];
      end else if (ADDR_IN < `CAFE_OFS_CTRL) begin
         rdata_nxt = mask_r[ADDR_IN[2:0]];
      end else begin
         case (ADDR_IN)
            `CAFE_OFS_CTRL:     rdata_nxt = {recovery_on_request_select_r, 1'b0, org_r, 1'b0, hit_r};
            `CAFE_OFS_MISC:     rdata_nxt = {7'h00, hold_r};
            `CAFE_OFS_RXERR:    rdata_nxt = rx_err_r;
            `CAFE_OFS_TXERR:    rdata_nxt = tx_err_r;
            `CAFE_OFS_IRQ_STAT: rdata_nxt = {5'h00, irq_stat_r};
            `CAFE_OFS_IRQ_MASK: rdata_nxt = {5'h00, irq_mask_r};
            default:            rdata_nxt = `CAFE_RST_BYTE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         for (i = 0; i < NUM_FILT_REGS; i = i + 1) begin
            code_r[i] <= `CAFE_RST_BYTE;
            mask_r[i] <= `CAFE_RST_BYTE;
         end
         org_r            <= `CAFE_RST_ORG;
         recovery_on_request_select_r           <= 1'b0;
         hold_r           <= 1'b0;
         bg_hit_r         <= 3'h0;
         bg_acc_r         <= 1'b0;
         hit_r            <= 3'h0;
         irq_stat_r       <= 3'h0;
         irq_mask_r       <= 3'h0;
         rx_err_r         <= `CAFE_RST_BYTE;
         tx_err_r         <= `CAFE_RST_BYTE;
         RDATA_OUT        <= `CAFE_RST_BYTE;
         FRAME_ACCEPT_OUT <= 1'b0;
         FRAME_DROP_OUT   <= 1'b0;
         BUSOFF_HOLD_OUT  <= 1'b0;
         IRQ_OUT          <= 1'b0;
      end else begin
         // counters copied each cycle; no write path exists
         rx_err_r <= RX_ERR_COUNT_IN;
         tx_err_r <= TX_ERR_COUNT_IN;
         // read data shows counts one cycle older than the read, in every mode
         RDATA_OUT <= RD_IN ? rdata_nxt : `CAFE_RST_BYTE;
         // filter setup only under acknowledged init mode
         if (WR_IN && init_mode) begin
            if (ADDR_IN < `CAFE_OFS_MASK0) begin
               code_r[ADDR_IN[2:0]] <= WDATA_IN;
            end else if (ADDR_IN < `CAFE_OFS_CTRL) begin
               mask_r[ADDR_IN[2:0]] <= WDATA_IN;
            end else if (ADDR_IN == `CAFE_OFS_CTRL) begin
               org_r  <= WDATA_IN[`CAFE_CTRL_ORG_HI:`CAFE_CTRL_ORG_LO];
               recovery_on_request_select_r <= WDATA_IN[`CAFE_CTRL_RECOVERY_ON_REQUEST_SELECT];
            end
         end
         if (WR_IN && ADDR_IN == `CAFE_OFS_IRQ_MASK) begin
            irq_mask_r <= WDATA_IN[2:0];
         end
         // hold flag: entry sets, a written one clears, set wins
         if (BUSOFF_ENTER_IN && recovery_on_request_select_r) begin
            hold_r <= 1'b1;
         end else if (wr_misc && WDATA_IN[`CAFE_MISC_HOLD]) begin
            hold_r <= 1'b0;
         end
         BUSOFF_HOLD_OUT <= (BUSOFF_ENTER_IN && recovery_on_request_select_r) ? 1'b1 :
                            (wr_misc && WDATA_IN[`CAFE_MISC_HOLD]) ? 1'b0 : hold_r;
         // every frame overwrites the background result
         FRAME_ACCEPT_OUT <= FRAME_VALID_IN & accept_nxt;
         FRAME_DROP_OUT   <= FRAME_VALID_IN & ~accept_nxt;
         if (FRAME_VALID_IN) begin
            bg_acc_r <= accept_nxt;
            bg_hit_r <= hit_nxt;
         end
         if (FG_LOAD_IN && bg_acc_r) begin
            hit_r <= bg_hit_r;
         end
         // sticky events; a read clears but a new event wins
         irq_stat_r <= (rd_stat ? 3'h0 : irq_stat_r)
                       | {BUSOFF_ENTER_IN & recovery_on_request_select_r,
                          FRAME_VALID_IN & ~accept_nxt,
                          FRAME_VALID_IN & accept_nxt};
         IRQ_OUT <= |(irq_stat_r & irq_mask_r) & ~rd_stat
                    | |({BUSOFF_ENTER_IN & recovery_on_request_select_r, FRAME_VALID_IN & ~accept_nxt,
                         FRAME_VALID_IN & accept_nxt} & irq_mask_r);
      end
   end

endmodule
`default_nettype wire

// File: tb/cafe_checker.sv
/*
 port checker for the acceptance filter and error counter block.
 assumes it is bound to cafe_top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module cafe_checker #(
   parameter NUM_FILT_REGS = 8
) (
   input wire logic       CLOCK_IN, ARST_N_IN, WR_IN, RD_IN, BUSOFF_ENTER_IN,
   input wire logic       FRAME_VALID_IN, FRAME_ACCEPT_OUT, FRAME_DROP_OUT,
   input wire logic       BUSOFF_HOLD_OUT,
   input wire logic [4:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN, RDATA_OUT, RX_ERR_COUNT_IN, TX_ERR_COUNT_IN
);
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!ARST_N_IN);
   // a clear that collides with bus-off entry loses, so keep it out
   sequence s_clr;
      WR_IN && ADDR_IN == 5'h11 && WDATA_IN[0] && !BUSOFF_ENTER_IN;
   endsequence
   sequence s_rx;
      RD_IN && ADDR_IN == 5'h12;
   endsequence
   sequence s_tx;
      RD_IN && ADDR_IN == 5'h13;
   endsequence
   chk_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
      else $error("read data not idle");
   chk_rx_view: assert property (s_rx |=> RDATA_OUT == $past(RX_ERR_COUNT_IN, 2))
      else $error("rx count view wrong");
   chk_tx_view: assert property (s_tx |=> RDATA_OUT == $past(TX_ERR_COUNT_IN, 2))
      else $error("tx count view wrong");
   chk_hold_cause: assert property ($rose(BUSOFF_HOLD_OUT) |-> $past(BUSOFF_ENTER_IN))
      else $error("hold set without bus-off");
   chk_hold_clear: assert property ($fell(BUSOFF_HOLD_OUT)
      |-> $past(WR_IN && ADDR_IN == 5'h11 && WDATA_IN[0]))
      else $error("hold cleared without request");
   chk_hold_keep: assert property (BUSOFF_HOLD_OUT
      && !(WR_IN && ADDR_IN == 5'h11 && WDATA_IN[0]) |=> BUSOFF_HOLD_OUT)
      else $error("hold dropped");
   chk_w1c_clear: assert property (s_clr |=> !BUSOFF_HOLD_OUT)
      else $error("write one did not clear hold");
   chk_one_result: assert property (FRAME_VALID_IN |=> FRAME_ACCEPT_OUT != FRAME_DROP_OUT)
      else $error("frame without single verdict");
   chk_no_verdict: assert property (!FRAME_VALID_IN |=> !FRAME_ACCEPT_OUT && !FRAME_DROP_OUT)
      else $error("verdict without frame");
endmodule
bind cafe_top cafe_checker #(.NUM_FILT_REGS(NUM_FILT_REGS)) i_chk (.*);
`default_nettype wire

// File: tb/cafe_node.sv
/*
 model of the far bus nodes: delivers frames, foreground loads and bus-off entry.
 assumes callers enter its tasks after a clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module cafe_node (
   input  wire logic        clk_in,
   output var  logic        valid_out, ext_out, load_out, busoff_out,
   output var  logic [31:0] id_out
);
   initial begin
      valid_out = 1'b0;
      ext_out = 1'b0;
      load_out = 1'b0;
      busoff_out = 1'b0;
      id_out = 32'h0;
   end
   // identifier inverted when idle so stale bytes never look valid
   task automatic send(input logic ext, input logic [31:0] id);
      @(posedge clk_in);
      valid_out <= 1'b1;
      ext_out <= ext;
      id_out <= id;
      @(posedge clk_in);
      valid_out <= 1'b0;
      id_out <= ~id;
   endtask
   task automatic strobe(input logic bo);
      @(posedge clk_in);
      if (bo) busoff_out <= 1'b1;
      else load_out <= 1'b1;
      @(posedge clk_in);
      busoff_out <= 1'b0;
      load_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/can_accept_filter_errctr_test.sv
/*
 self-checking bench for the acceptance filter and error counter block.
 assumes cafe_top, cafe_node and the bound checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module can_accept_filter_errctr_test;
   logic        clk = 0, arst_n = 0, wr = 0, rd = 0, ireq = 0, iack = 0, slp = 0;
   logic        acc, drop, hold, irq, fv, fx, fl, bo;
   logic [4:0]  addr = 5'h00;
   logic [7:0]  wd = 8'h00, rxc = 8'h00, txc = 8'h00, rdat, rb, code [8], mask [8];
   logic [31:0] fid, ids [4];
   logic [3:0]  hit = 4'h0, ex;
   int          mismatches = 0, checked = 0;
   always #5 clk = ~clk;
   cafe_top #(.NUM_FILT_REGS(8)) i_dut (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .ADDR_IN(addr),
      .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat), .INIT_REQUEST_IN(ireq),
      .INIT_ACKNOWLEDGE_IN(iack), .SLEEP_REQUEST_IN(slp), .SLEEP_ACKNOWLEDGE_IN(slp),
      .RX_ERR_COUNT_IN(rxc), .TX_ERR_COUNT_IN(txc), .BUSOFF_ENTER_IN(bo),
      .FRAME_VALID_IN(fv), .FRAME_EXTENDED_IN(fx), .FRAME_ID_IN(fid), .FG_LOAD_IN(fl),
      .FRAME_ACCEPT_OUT(acc), .FRAME_DROP_OUT(drop), .BUSOFF_HOLD_OUT(hold), .IRQ_OUT(irq));
   cafe_node i_node (.clk_in(clk), .valid_out(fv), .ext_out(fx), .load_out(fl),
      .busoff_out(bo), .id_out(fid));
   task automatic chk(input string n, input logic [7:0] e, g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr8(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd8(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
   endtask
   // reference filter, lowest matching filter wins
   function automatic logic [3:0] model(input logic [1:0] o, input logic x, input logic [31:0] id);
      int nf, np, r;
      logic ok;
      nf = (o == 2'h0) ? 2 : (o == 2'h1) ? 4 : (o == 2'h2) ? 8 : 0;
      np = (o == 2'h0) ? (x ? 4 : 2) : (o == 2'h1) ? 2 : 1;
      for (int f = 0; f < nf; f++) begin
         ok = 1'b1;
         for (int k = 0; k < np; k++) begin
            r = f * (8 / nf) + k;
            if (((id[31 - 8 * k -: 8] ^ code[r]) & ~mask[r]) != 8'h00) ok = 1'b0;
         end
         if (ok) return {1'b1, 3'(f)};
      end
      return 4'h0;
   endfunction
   task automatic t_regs;
      for (int i = 0; i < 16; i++) begin
         rd8(5'(i), rb);
         chk("filter reset", 8'h00, rb);
      end
      wr8(5'h00, 8'h5a);
      rd8(5'h00, rb);
      chk("write outside init", 8'h00, rb);
      rd8(5'h1f, rb);
      chk("unmapped", 8'h00, rb);
      $display("t_regs done");
   endtask
   task automatic t_filter;
      iack <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         code[i] = 8'(8'h13 * (i + 1));
         mask[i] = (i == 1 || i == 5 || i == 7) ? 8'h07 : (i == 3) ? 8'hf7 : 8'h00;
         wr8(5'(i), code[i]);
         wr8(5'(i + 8), mask[i]);
         rd8(5'(i), rb);
         chk("code readback", code[i], rb);
         rd8(5'(i + 8), rb);
         chk("mask readback", mask[i], rb);
      end
      ids = '{{code[0], code[1] ^ 8'h01, code[2], code[3]},
              {code[4], code[5], code[6], code[7] ^ 8'h80},
              {code[6], code[6], 8'h00, 8'h00}, {code[2], code[3] ^ 8'h40, 16'hffff}};
      for (int o = 0; o < 4; o++) begin
         wr8(5'h10, {2'b10, 2'(o), 4'h0});
         for (int n = 0; n < 8; n++) begin
            ex = model(2'(o), n[0], ids[n >> 1]);
            i_node.send(n[0], ids[n >> 1]);
            #1 chk("accept", {7'h0, ex[3]}, {7'h0, acc});
            chk("drop", {7'h0, !ex[3]}, {7'h0, drop});
            if (ex[3]) hit = ex;
            i_node.strobe(1'b0);
            rd8(5'h10, rb);
            chk("hit index", {5'h0, hit[2:0]}, {5'h0, rb[2:0]});
         end
      end
      $display("t_filter done");
   endtask
   task automatic t_count;
      rxc <= 8'h5a;
      txc <= 8'hc3;
      wr8(5'h12, 8'h00);
      wr8(5'h13, 8'h00);
      slp <= 1'b1;
      rd8(5'h12, rb);
      chk("rx count", 8'h5a, rb);
      rd8(5'h13, rb);
      chk("tx count", 8'hc3, rb);
      $display("t_count done");
   endtask
   task automatic t_busoff;
      rd8(5'h14, rb);
      chk("frame events", 8'h03, rb);
      wr8(5'h15, 8'h04);
      rd8(5'h15, rb);
      chk("irq mask", 8'h04, rb);
      i_node.strobe(1'b1);
      #1 chk("hold set", 8'h01, {7'h0, hold});
      repeat (2) @(posedge clk);
      #1 chk("irq raised", 8'h01, {7'h0, irq});
      wr8(5'h11, 8'h00);
      rd8(5'h11, rb);
      chk("hold kept", 8'h01, rb);
      rd8(5'h14, rb);
      chk("status", 8'h04, rb);
      repeat (2) @(posedge clk);
      #1 chk("irq cleared", 8'h00, {7'h0, irq});
      wr8(5'h11, 8'h01);
      rd8(5'h11, rb);
      chk("hold cleared", 8'h00, rb);
      wr8(5'h15, 8'h00);
      i_node.strobe(1'b1);
      repeat (2) @(posedge clk);
      #1 chk("irq masked", 8'h00, {7'h0, irq});
      wr8(5'h11, 8'h01);
      wr8(5'h10, 8'h00);
      i_node.strobe(1'b1);
      #1 chk("hold without select", 8'h00, {7'h0, hold});
      $display("t_busoff done");
   endtask
   task automatic results;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      ireq <= 1'b1;
      t_regs;
      t_filter;
      t_count;
      t_busoff;
      results;
   end
   // whole run needs a few hundred cycles
   initial begin
      #200000;
      mismatches++;
      results;
   end
endmodule
`default_nettype wire
